// *** hdl/eafm_fault_manager.sv ***
// Top of the enclosure alarm and fault manager.
`timescale 1ns/1ps
`default_nettype none

module eafm_fault_manager
	import eafm_pkg::*;
#(
	parameter logic [CD_W-1:0] CD_CYC = CD_CYCLES,
	parameter logic [HOUR_W-1:0] HOUR_CYC = HOUR_CYCLES,
	parameter logic [HOLD_W-1:0] HOLD_CYC = HOLD_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [NUM_BLOWERS-1:0] blower_failed,
	input wire logic [NUM_BLOWERS-1:0] blower_removed,
	input wire logic [NUM_BLOWERS-1:0] blower_slow,
	input wire logic [TEMP_W-1:0] intake_temp,
	input wire logic [TEMP_W-1:0] exhaust_a_temp,
	input wire logic [TEMP_W-1:0] exhaust_b_temp,
	input wire logic [SETPT_W-1:0] intake_setpoint,
	input wire logic [SETPT_W-1:0] exhaust_setpoint,
	input wire logic blower_speed_select,
	input wire logic power_fault,
	input wire logic other_component_failed,
	input wire logic controlled_shutdown,
	input wire logic alarm_switch,
	output logic [NUM_BLOWERS-1:0] blower_high,
	output logic audible_alarm,
	output logic switch_led,
	output logic system_fault_led,
	output logic temp_fault_led,
	output logic system_ok_led,
	output logic fault_led,
	output logic blower_led_codes,
	output logic [ERR_W-1:0] ctrl_error_code,
	output logic ctrl_subsys_ok,
	output logic ctrl_report,
	output logic [ERR_W-1:0] stored_fault_codes,
	output logic countdown_active,
	output logic countdown_timeout,
	output logic dc_power_restore
);

	// ----------------------------------------------------------------
	// Error detection
	// ----------------------------------------------------------------

	// Strictly above the setpoint counts as over-temperature.
	function automatic logic temp_over(input logic [TEMP_W-1:0] t,
		input logic [SETPT_W-1:0] sp);
		temp_over = t > {2'h0, sp};
	endfunction : temp_over

	logic [ERR_W-1:0] err_now; // Live error conditions this cycle.
	logic [NUM_BANKS-1:0] bank_dead; // Every blower of the bank has failed.
	logic cd_trigger; // Condition that runs the countdown.

	// Setpoints are trusted to be whole degrees in range. RULE_03
	always_comb begin
		err_now = ERR_NONE;
		err_now[ERR_FAIL] = |blower_failed; // RULE_01
		err_now[ERR_REMOVED] = |blower_removed; // RULE_01
		err_now[ERR_SLOW] = |blower_slow; // RULE_01
		err_now[ERR_INTAKE] = temp_over(intake_temp, intake_setpoint); // RULE_01
		err_now[ERR_EXHAUST] = temp_over(exhaust_a_temp, exhaust_setpoint)
			| temp_over(exhaust_b_temp, exhaust_setpoint); // RULE_01
		err_now[ERR_POWER] = power_fault;
	end

	// One bank-loss detector per bank.
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		assign bank_dead[b] = &blower_failed[b*BANK_SIZE +: BANK_SIZE];
	end

	assign cd_trigger = (|bank_dead) | (|blower_removed); // RULE_07

	// ----------------------------------------------------------------
	// Switch classifier
	// ----------------------------------------------------------------
	eafm_sw_if sw ();

	eafm_press_timer #(
		.HOLD_CYC(HOLD_CYC)
	) u_press (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.alarm_switch(alarm_switch),
		.sw(sw.timer)
	);

	// ----------------------------------------------------------------
	// Blower speed and indicators
	// ----------------------------------------------------------------
	logic [NUM_BLOWERS-1:0] high_reg, high_next; // Per-blower high speed.
	logic tfault_reg, tfault_next; // Temperature fault lamp.
	logic sfault_reg, sfault_next; // System fault lamp.
	logic ok_reg, ok_next; // Green system OK lamp.
	logic fault_reg, fault_next; // Amber fault lamp.

	// A failed or removed blower is not driven; the rest run fast on any error.
	always_comb begin
		for (int i = 0; i < NUM_BLOWERS; i++) begin
			high_next[i] = (blower_speed_select | (|err_now)) // RULE_02 RULE_04
				& ~blower_failed[i] & ~blower_removed[i];
		end
		tfault_next = err_now[ERR_INTAKE] | err_now[ERR_EXHAUST]; // RULE_05
		sfault_next = tfault_next; // RULE_05
		fault_next = (|err_now) | other_component_failed; // RULE_15
		ok_next = !fault_next; // RULE_15
	end

	// Indicator registers.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			high_reg <= '0;
			tfault_reg <= 1'b0;
			sfault_reg <= 1'b0;
			ok_reg <= 1'b0;
			fault_reg <= 1'b0;
		end else if (clk_en) begin
			high_reg <= high_next;
			tfault_reg <= tfault_next;
			sfault_reg <= sfault_next;
			ok_reg <= ok_next;
			fault_reg <= fault_next;
		end
	end

	// ----------------------------------------------------------------
	// Audible alarm, silencing and power restore
	// ----------------------------------------------------------------
	logic [ERR_W-1:0] mask_reg, mask_next; // Faults silenced by a press.
	logic [HOUR_W-1:0] hour_reg, hour_next; // Time spent silenced.
	logic alarm_reg, alarm_next; // Audible alarm and switch lamp.
	logic codes_reg, codes_next; // Blower lamps show fault codes.
	logic restore_reg, restore_next; // Power restore pulse.

	// Cleared faults drop out of the mask, so a recurrence sounds again.
	always_comb begin
		mask_next = mask_reg & err_now; // RULE_11
		hour_next = '0;
		restore_next = 1'b0;
		if (|mask_reg) begin
			if (hour_reg == HOUR_CYC - 1'b1) begin
				mask_next = ERR_NONE; // RULE_11
			end else begin
				hour_next = hour_reg + 1'b1;
			end
		end
		if (sw.short_press) begin
			if (controlled_shutdown) begin
				restore_next = 1'b1; // RULE_14
			end else begin
				mask_next = err_now; // RULE_10
				hour_next = '0;
			end
		end
		alarm_next = |(err_now & ~mask_next); // RULE_08 RULE_09 RULE_11
		codes_next = |mask_next; // RULE_10
	end

	// Alarm registers.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mask_reg <= ERR_NONE;
			hour_reg <= '0;
			alarm_reg <= 1'b0;
			codes_reg <= 1'b0;
			restore_reg <= 1'b0;
		end else if (clk_en) begin
			mask_reg <= mask_next;
			hour_reg <= hour_next;
			alarm_reg <= alarm_next;
			codes_reg <= codes_next;
			restore_reg <= restore_next;
		end
	end

	// ----------------------------------------------------------------
	// Stored codes and controller report
	// ----------------------------------------------------------------
	logic [ERR_W-1:0] stored_reg, stored_next; // Fault code history.
	logic [ERR_W-1:0] cerr_reg, cerr_next; // Error code sent upstream.
	logic cok_reg, cok_next; // Subsystem status sent upstream.
	logic rep_reg, rep_next; // Report strobe on any change.

	// A hold wipes history but live conditions stay recorded.
	always_comb begin
		stored_next = stored_reg | err_now;
		if (sw.long_hold) begin
			stored_next = err_now; // RULE_12 RULE_13
		end
		cerr_next = err_now; // RULE_06
		cok_next = ok_next; // RULE_06
		rep_next = (err_now != cerr_reg) | (ok_next != cok_reg); // RULE_06
	end

	// Report registers.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stored_reg <= ERR_NONE;
			cerr_reg <= ERR_NONE;
			cok_reg <= 1'b0;
			rep_reg <= 1'b0;
		end else if (clk_en) begin
			stored_reg <= stored_next;
			cerr_reg <= cerr_next;
			cok_reg <= cok_next;
			rep_reg <= rep_next;
		end
	end

	// ----------------------------------------------------------------
	// Blower-loss countdown
	// ----------------------------------------------------------------
	logic [CD_W-1:0] cd_reg, cd_next; // Countdown elapsed cycles.
	logic cact_reg, cact_next; // Countdown running.
	logic tout_reg, tout_next; // Countdown expired.

	// Timeout holds until the cause is removed; recovery restarts from zero.
	always_comb begin
		cd_next = '0;
		tout_next = 1'b0;
		cact_next = 1'b0;
		if (cd_trigger) begin
			tout_next = tout_reg;
			cd_next = cd_reg;
			if (tout_reg || cd_reg == CD_CYC - 1'b1) begin
				tout_next = 1'b1; // RULE_16
			end else begin
				cd_next = cd_reg + 1'b1; // RULE_07
				cact_next = 1'b1;
			end
		end
	end

	// Countdown registers.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cd_reg <= '0;
			cact_reg <= 1'b0;
			tout_reg <= 1'b0;
		end else if (clk_en) begin
			cd_reg <= cd_next;
			cact_reg <= cact_next;
			tout_reg <= tout_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign blower_high = high_reg;
	assign audible_alarm = alarm_reg;
	assign switch_led = alarm_reg; // RULE_08
	assign system_fault_led = sfault_reg;
	assign temp_fault_led = tfault_reg;
	assign system_ok_led = ok_reg;
	assign fault_led = fault_reg;
	assign blower_led_codes = codes_reg;
	assign ctrl_error_code = cerr_reg;
	assign ctrl_subsys_ok = cok_reg;
	assign ctrl_report = rep_reg;
	assign stored_fault_codes = stored_reg;
	assign countdown_active = cact_reg;
	assign countdown_timeout = tout_reg;
	assign dc_power_restore = restore_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_err_high;
		@(posedge sys_clk) disable iff (rst)
		clk_en && (|err_now) && !blower_failed[0] && !blower_removed[0] |=> blower_high[0];
	endproperty
	a_err_high: assert property (p_err_high) else $error("blower not forced high"); // RULE_04

	property p_temp_leds;
		@(posedge sys_clk) disable iff (rst)
		clk_en && temp_over(intake_temp, intake_setpoint)
			|=> temp_fault_led && system_fault_led;
	endproperty
	a_temp_leds: assert property (p_temp_leds) else $error("temp lamps off"); // RULE_05

	property p_report;
		@(posedge sys_clk) disable iff (rst)
		clk_en |=> ctrl_error_code == $past(err_now);
	endproperty
	a_report: assert property (p_report) else $error("report stale"); // RULE_06

	property p_alarm_on;
		@(posedge sys_clk) disable iff (rst)
		clk_en && (|err_now) && mask_reg == ERR_NONE && !sw.short_press
			|=> audible_alarm && switch_led;
	endproperty
	a_alarm_on: assert property (p_alarm_on) else $error("alarm silent on fault"); // RULE_08

	property p_alarm_off;
		@(posedge sys_clk) disable iff (rst)
		clk_en && err_now == ERR_NONE |=> !audible_alarm;
	endproperty
	a_alarm_off: assert property (p_alarm_off) else $error("alarm after fix"); // RULE_09

	property p_silence;
		@(posedge sys_clk) disable iff (rst)
		clk_en && sw.short_press && !controlled_shutdown && (|err_now)
			|=> !audible_alarm && blower_led_codes && fault_led;
	endproperty
	a_silence: assert property (p_silence) else $error("press did not silence"); // RULE_10

	property p_resound;
		@(posedge sys_clk) disable iff (rst)
		clk_en && (|mask_reg) && !sw.short_press && (|(err_now & ~mask_reg))
			|=> audible_alarm;
	endproperty
	a_resound: assert property (p_resound) else $error("new fault stayed silent"); // RULE_11

	property p_hold_clear;
		@(posedge sys_clk) disable iff (rst)
		clk_en && sw.long_hold |=> stored_fault_codes == $past(err_now);
	endproperty
	a_hold_clear: assert property (p_hold_clear) else $error("codes not cleared"); // RULE_12 RULE_13

	property p_restore;
		@(posedge sys_clk) disable iff (rst)
		// A silenced fault may still clear or time out here; only new silencing is barred.
		clk_en && sw.short_press && controlled_shutdown
			|=> dc_power_restore && (mask_reg & ~$past(mask_reg)) == ERR_NONE;
	endproperty
	a_restore: assert property (p_restore) else $error("no power restore"); // RULE_14

	property p_ok_amber;
		@(posedge sys_clk) disable iff (rst)
		clk_en && !rst ##1 1'b1 |-> system_ok_led != fault_led;
	endproperty
	a_ok_amber: assert property (p_ok_amber) else $error("ok and fault agree"); // RULE_15

	property p_cd_count;
		@(posedge sys_clk) disable iff (rst)
		clk_en && cd_trigger && !tout_reg && cd_reg != CD_CYC - 1'b1
			|=> cd_reg == $past(cd_reg) + 1'b1;
	endproperty
	a_cd_count: assert property (p_cd_count) else $error("countdown stalled"); // RULE_07

	property p_cd_reset;
		@(posedge sys_clk) disable iff (rst)
		clk_en && !cd_trigger |=> !countdown_timeout && cd_reg == '0;
	endproperty
	a_cd_reset: assert property (p_cd_reset) else $error("countdown not reset"); // RULE_16

endmodule : eafm_fault_manager

`default_nettype wire

// *** hdl/eafm_pkg.sv ***
// Constants and types shared by the enclosure alarm and fault manager.
// Functional notes
// (RULE_01) Blower fail, removal, slowness, over-temperature are errors.
// (RULE_02) Forced high runs all blowers fast; failed or removed blowers are not driven high.
// (RULE_03) Setpoints arrive as whole Celsius, 0 to 49.
// (RULE_04) Any error drives working blowers high at once.
// (RULE_05) Over-temperature lights system and temperature fault.
// (RULE_06) Report every error and subsystem status upstream.
// (RULE_07) Bank loss or removal starts eight-minute countdown.
// (RULE_08) Any fault sounds alarm and lights switch lamp.
// (RULE_09) Alarm holds until corrected or press silences.
// (RULE_10) Press silences current faults; blower lamps show codes.
// (RULE_11) Re-sound after hour, new fault, or recurrence.
// (RULE_12) Five-second hold clears stored fault codes.
// (RULE_13) Presses never clear a live error condition.
// (RULE_14) In shutdown a press restores enclosure power.
// (RULE_15) Green OK when normal, amber on failure.
// (RULE_16) Countdown resets on recovery, flags timeout on expiry.
`default_nettype none

package eafm_pkg;

	// ----------------------------------------------------------------
	// Enclosure shape
	// ----------------------------------------------------------------
	localparam int NUM_BLOWERS = 8; // Blowers in the enclosure.
	localparam int NUM_BANKS = 2; // Blowers are grouped into equal banks.
	localparam int BANK_SIZE = NUM_BLOWERS / NUM_BANKS; // Blowers per bank.
	localparam int TEMP_W = 8; // Measured temperature, whole degrees Celsius.
	localparam int SETPT_W = 6; // Setpoint, whole degrees Celsius 0 to 49.

	// ----------------------------------------------------------------
	// Error vector layout
	// ----------------------------------------------------------------
	localparam int ERR_W = 6; // Width of the error code vector.
	localparam int ERR_FAIL = 0; // A blower has failed.
	localparam int ERR_REMOVED = 1; // A blower is removed.
	localparam int ERR_SLOW = 2; // A blower turns too slowly.
	localparam int ERR_INTAKE = 3; // Intake above its setpoint.
	localparam int ERR_EXHAUST = 4; // An exhaust sensor above its setpoint.
	localparam int ERR_POWER = 5; // Power fault.
	localparam logic [ERR_W-1:0] ERR_NONE = 6'h00; // Error vector after reset.

	// ----------------------------------------------------------------
	// Timing, clock at 250 MHz (4 ns period)
	// ----------------------------------------------------------------
	localparam longint unsigned CLK_HZ = 64'd250000000; // System clock rate.
	localparam longint unsigned COUNTDOWN_MIN = 64'd8; // Blower-loss countdown, minutes.
	localparam longint unsigned SILENCE_MIN = 64'd60; // Silence period, one hour.
	localparam longint unsigned HOLD_SEC = 64'd5; // Hold time that clears codes.
	localparam int CD_W = 37; // Countdown counter width.
	localparam int HOUR_W = 40; // Silence counter width.
	localparam int HOLD_W = 31; // Hold counter width.
	localparam logic [CD_W-1:0] CD_CYCLES = CD_W'(COUNTDOWN_MIN * 64'd60 * CLK_HZ);
	localparam logic [HOUR_W-1:0] HOUR_CYCLES = HOUR_W'(SILENCE_MIN * 64'd60 * CLK_HZ);
	localparam logic [HOLD_W-1:0] HOLD_CYCLES = HOLD_W'(HOLD_SEC * CLK_HZ);

	// Switch press classifier states.
	typedef enum logic [1:0] {
		SW_IDLE,
		SW_HELD,
		SW_LONG
	} eafm_sw_state_t;

endpackage : eafm_pkg

`default_nettype wire

// *** hdl/eafm_press_timer.sv ***
// Alarm control switch press classifier: momentary press versus long hold.
`timescale 1ns/1ps
`default_nettype none

module eafm_press_timer
	import eafm_pkg::*;
#(
	parameter logic [HOLD_W-1:0] HOLD_CYC = HOLD_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic alarm_switch,
	eafm_sw_if.timer sw
);

	// ----------------------------------------------------------------
	// Press state machine
	// ----------------------------------------------------------------
	eafm_sw_state_t state_reg, state_next; // Classifier state.
	logic [HOLD_W-1:0] cnt_reg, cnt_next; // Cycles the switch has been held.
	logic short_reg, short_next; // Momentary press pulse.
	logic long_reg, long_next; // Long hold pulse.

	// A long hold never also yields a momentary press on release.
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		short_next = 1'b0;
		long_next = 1'b0;
		case (state_reg)
			SW_IDLE: begin
				cnt_next = '0;
				if (alarm_switch) begin
					state_next = SW_HELD;
				end
			end
			SW_HELD: begin
				if (!alarm_switch) begin
					short_next = 1'b1;
					state_next = SW_IDLE;
				end else if (cnt_reg == HOLD_CYC - 1'b1) begin
					long_next = 1'b1; // RULE_12
					state_next = SW_LONG;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			SW_LONG: begin
				if (!alarm_switch) begin
					state_next = SW_IDLE;
				end
			end
			default: begin
				state_next = SW_IDLE;
			end
		endcase
	end

	// Registers only; the clock enable freezes everything.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= SW_IDLE;
			cnt_reg <= '0;
			short_reg <= 1'b0;
			long_reg <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			short_reg <= short_next;
			long_reg <= long_next;
		end
	end

	assign sw.short_press = short_reg;
	assign sw.long_hold = long_reg;

	// A long hold pulse is never followed by a momentary press pulse, even on release.
	property p_hold_no_short;
		@(posedge sys_clk) disable iff (rst)
		state_reg == SW_LONG |=> !short_reg;
	endproperty
	a_hold_no_short: assert property (p_hold_no_short) else $error("hold also gave press"); // RULE_12

endmodule : eafm_press_timer

`default_nettype wire

// *** hdl/eafm_sw_if.sv ***
// Interface carrying classified alarm switch presses to the manager.
`timescale 1ns/1ps
`default_nettype none

interface eafm_sw_if;
	logic short_press; // One-cycle pulse on release of a press shorter than the hold time.
	logic long_hold; // One-cycle pulse when the hold time is reached while pressed.

	modport timer (output short_press, output long_hold);
	modport mgr (input short_press, input long_hold);
endinterface : eafm_sw_if

`default_nettype wire

// *** test/eafm_ctrl_model.sv ***
// Array controller and front-panel switch model facing the fault manager.
`timescale 1ns/1ps
`default_nettype none

module eafm_ctrl_model
	import eafm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ctrl_report,
	input wire logic [ERR_W-1:0] ctrl_error_code,
	input wire logic ctrl_subsys_ok,
	output var logic alarm_switch
);
	// ------------------------------------------------------------
	// Controller log
	// ------------------------------------------------------------
	logic [ERR_W-1:0] last_code; // Code captured at the latest report.
	logic last_ok; // Subsystem status captured at the latest report.
	int reports; // Reports seen since reset.

	// The log is taken only on the report pulse, as a real controller would.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			last_code <= ERR_NONE;
			last_ok <= 1'b0;
			reports <= 0;
		end else if (ctrl_report) begin
			last_code <= ctrl_error_code;
			last_ok <= ctrl_subsys_ok;
			reports <= reports + 1;
		end
	end

	// ------------------------------------------------------------
	// Switch
	// ------------------------------------------------------------
	initial alarm_switch = 1'b0; // A released switch reads low.

	// Holds the switch for n sys_clk edges, whatever clk_en is; the caller spaces presses apart.
	task automatic press(input int n);
		@(posedge sys_clk);
		alarm_switch <= 1'b1;
		repeat (n) @(posedge sys_clk);
		alarm_switch <= 1'b0;
	endtask : press
endmodule : eafm_ctrl_model

`default_nettype wire

// *** test/eafm_fault_manager_tb.sv ***
// Self-checking testbench of the enclosure alarm and fault manager.
`timescale 1ns/1ps
`default_nettype none

module eafm_fault_manager_tb
	import eafm_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic sys_clk, rst, clk_en, speed, pwr, other, shut;
	logic [7:0] b_fail, b_rem, b_slow, t_in, t_ea, t_eb;
	logic [SETPT_W-1:0] sp_in, sp_ex;
	logic alarm_switch, audible_alarm, switch_led, system_fault_led, temp_fault_led;
	logic system_ok_led, fault_led, blower_led_codes, ctrl_subsys_ok, ctrl_report;
	logic countdown_active, countdown_timeout, dc_power_restore, hit;
	logic [7:0] blower_high;
	logic [ERR_W-1:0] ctrl_error_code, stored_fault_codes;
	int err_total, compares, cyc;
	// Expected code and blower pattern of each fault source in set_src.
	logic [5:0] xc [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h10, 6'h20, 6'h00};
	logic [7:0] xh [8] = '{8'hFE, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};

	// Short counts keep the run brief: countdown 20, silence 40, hold 5.
	eafm_fault_manager #(.CD_CYC(CD_W'(8'h14)), .HOUR_CYC(HOUR_W'(8'h28)),
		.HOLD_CYC(HOLD_W'(8'h05))) dut_u (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
		.blower_failed(b_fail), .blower_removed(b_rem), .blower_slow(b_slow),
		.intake_temp(t_in), .exhaust_a_temp(t_ea), .exhaust_b_temp(t_eb),
		.intake_setpoint(sp_in), .exhaust_setpoint(sp_ex), .blower_speed_select(speed),
		.power_fault(pwr), .other_component_failed(other), .controlled_shutdown(shut),
		.alarm_switch(alarm_switch), .blower_high(blower_high),
		.audible_alarm(audible_alarm), .switch_led(switch_led),
		.system_fault_led(system_fault_led), .temp_fault_led(temp_fault_led),
		.system_ok_led(system_ok_led), .fault_led(fault_led),
		.blower_led_codes(blower_led_codes), .ctrl_error_code(ctrl_error_code),
		.ctrl_subsys_ok(ctrl_subsys_ok), .ctrl_report(ctrl_report),
		.stored_fault_codes(stored_fault_codes), .countdown_active(countdown_active),
		.countdown_timeout(countdown_timeout), .dc_power_restore(dc_power_restore));

	eafm_ctrl_model ctrl_u (.sys_clk(sys_clk), .rst(rst), .ctrl_report(ctrl_report),
		.ctrl_error_code(ctrl_error_code), .ctrl_subsys_ok(ctrl_subsys_ok),
		.alarm_switch(alarm_switch));

	// ------------------------------------------------------------
	// Clock and hang guard
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// The tests need well under a thousand cycles; 3000 means a hang.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total = err_total + 1;
			close_out();
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk1(input logic e, input logic g);
		compares = compares + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("Error t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk1

	task automatic chk8(input logic [7:0] e, input logic [7:0] g);
		compares = compares + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("Error t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk8

	// Lets n edges land, then looks where outputs are settled.
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : settle

	// Raises or drops one fault source; called just after a rising edge.
	task automatic set_src(input int i, input logic on);
		case (i)
			0: b_fail <= on ? 8'h01 : 8'h00;
			1: b_rem <= on ? 8'h80 : 8'h00;
			2: b_slow <= on ? 8'h02 : 8'h00;
			3: t_in <= on ? 8'h1F : 8'h14;
			4: t_ea <= on ? 8'h28 : 8'h14;
			5: t_eb <= on ? 8'h28 : 8'h14;
			6: pwr <= on;
			default: other <= on;
		endcase
	endtask : set_src

	task automatic drive_src(input int i, input logic on);
		@(posedge sys_clk);
		set_src(i, on);
		settle(2);
	endtask : drive_src

	// Bounded wait for one output condition; hit tells whether it came.
	task automatic wait_for(input int w, input int maxc, output logic got);
		got = 1'b0;
		for (int k = 0; k < maxc && !got; k++) begin
			settle(1);
			case (w)
				0: got = (audible_alarm === 1'b1);
				1: got = (audible_alarm === 1'b0);
				2: got = (dc_power_restore === 1'b1);
				default: got = (countdown_timeout === 1'b1);
			endcase
		end
	endtask : wait_for

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		err_total = 0;
		compares = 0;
		cyc = 0;
		{rst, clk_en} = 2'b11;
		{speed, pwr, other, shut} = 4'h0;
		{b_fail, b_rem, b_slow} = 24'h000000;
		{t_in, t_ea, t_eb} = 24'h141414;
		sp_in = 6'h1E;
		sp_ex = 6'h23;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		settle(2);
		chk1(1'b1, system_ok_led);
		// A temperature equal to its setpoint is not yet a fault.
		@(posedge sys_clk);
		t_in <= 8'h1E;
		settle(2);
		chk8(8'h00, {2'b00, ctrl_error_code});
		// Every fault source in turn, then its correction.
		for (int i = 0; i < 8; i++) begin
			drive_src(i, 1'b1);
			chk8({2'b00, xc[i]}, {2'b00, ctrl_error_code});
			chk8({2'b00, xc[i]}, {2'b00, ctrl_u.last_code});
			chk1(1'b0, ctrl_u.last_ok);
			chk8(xh[i], blower_high);
			chk1(i < 7, audible_alarm);
			chk1(i < 7, switch_led);
			chk1(i > 2 && i < 6, system_fault_led);
			chk1(i > 2 && i < 6, temp_fault_led);
			chk1(1'b1, fault_led);
			chk1(1'b0, system_ok_led);
			drive_src(i, 1'b0);
			chk1(1'b0, audible_alarm);
			chk1(1'b1, system_ok_led);
		end
		// Silence, then the hour runs out.
		drive_src(3, 1'b1);
		ctrl_u.press(2);
		wait_for(1, 6, hit);
		chk1(1'b1, hit);
		settle(1);
		chk1(1'b1, blower_led_codes);
		chk1(1'b1, temp_fault_led);
		chk8(8'h08, {2'b00, ctrl_error_code});
		wait_for(0, 60, hit);
		chk1(1'b1, hit);
		// Silence, then a different fault arrives.
		ctrl_u.press(2);
		wait_for(1, 6, hit);
		drive_src(2, 1'b1);
		chk1(1'b1, audible_alarm);
		// A long hold, with the new fault still sounding, leaves only live codes stored.
		ctrl_u.press(9);
		settle(4);
		chk8(8'h0C, {2'b00, stored_fault_codes});
		chk8(8'h0C, {2'b00, ctrl_error_code});
		chk1(1'b1, audible_alarm);
		// Silence, clear the fault, then it recurs.
		ctrl_u.press(2);
		wait_for(1, 6, hit);
		drive_src(3, 1'b0);
		drive_src(3, 1'b1);
		chk1(1'b1, audible_alarm);
		drive_src(3, 1'b0);
		drive_src(2, 1'b0);
		// A full bank lost, recovered before expiry.
		@(posedge sys_clk);
		b_fail <= 8'h0F;
		settle(5);
		chk1(1'b1, countdown_active);
		drive_src(0, 1'b0);
		chk1(1'b0, countdown_active);
		chk1(1'b0, countdown_timeout);
		// A removed blower left until the countdown expires.
		drive_src(1, 1'b1);
		chk1(1'b1, countdown_active);
		wait_for(3, 30, hit);
		chk1(1'b1, hit);
		drive_src(1, 1'b0);
		chk1(1'b0, countdown_timeout);
		// Forced and automatic blower speed with no fault present; a low enable holds state.
		@(posedge sys_clk);
		clk_en <= 1'b0;
		speed <= 1'b1;
		settle(2);
		chk8(8'h00, blower_high);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		settle(2);
		chk8(8'hFF, blower_high);
		@(posedge sys_clk);
		speed <= 1'b0;
		settle(2);
		chk8(8'h00, blower_high);
		// During shutdown a press asks for power back.
		@(posedge sys_clk);
		shut <= 1'b1;
		ctrl_u.press(2);
		wait_for(2, 8, hit);
		chk1(1'b1, hit);
		close_out();
	end
endmodule : eafm_fault_manager_tb

`default_nettype wire
